// File: hdl/port_direction_pin_mux.sv
// Purpose: port direction, input-only masking and pin function selection
// Assumes: straps and pins are asynchronous; registers on a plain strobe port
// Notes:   read data appear in the cycle after the read strobe
//
// Function
// R01 - every programmable port bit has its own direction bit chosen by software.
// R02 - port 6 bit 4 is always an input carrying the system break request.
// R03 - port 9 bit 7 and port 22 bit 1 are input-only receive pins and ignore direction.
// R04 - port 9 bit 3, port 12 bits 4-7, port 13 and port 17 bits 2-3 never drive.
// R05 - each pin is shared between port use and a peripheral or bus signal.
// R06 - ports 0 to 4 and port 22 bit 5 take their function from the two straps.
// R07 - ports 6 to 22 take their function from the operation-mode register.
// R08 - only in extended mode may the register change ports 0-4, never port 4 bit 6.
// R09 - in single-chip and processor mode the straps alone fix ports 0-4.
// R10 - straps low give ports; strap b alone, or strap a with protect low, give the bus.
// R11 - after reset every port bit is an input so no pin is driven.
`timescale 1ns/1ps
`default_nettype none

module port_direction_pin_mux (
	input  wire logic         clk,
	input  wire logic         sys_rst,
	input  wire logic [7:0]   reg_addr,
	input  wire logic [7:0]   reg_wdata,
	input  wire logic         reg_write,
	input  wire logic         reg_read,
	output logic      [7:0]   reg_rdata,
	input  wire logic         mode_strap_a,
	input  wire logic         mode_strap_b,
	input  wire logic         flash_protect_pin,
	input  wire logic [183:0] pin_in,
	output logic      [183:0] pin_out,
	output logic      [183:0] pin_oe,
	input  wire logic [183:0] alt_out,
	input  wire logic [183:0] alt_oe,
	output logic      [183:0] alt_in,
	output logic      [183:0] alt_select,
	output logic              system_break_request,
	output logic      [2:0]   op_mode,
	output logic              mode_invalid
);

	localparam int W = port_mux_pkg::PIN_COUNT;

	logic [W-1:0] data_q;
	logic [W-1:0] dir_q;
	logic [W-1:0] opmode_q;
	logic [W-1:0] pin_s1_q;
	logic [W-1:0] pin_s2_q;
	logic [W-1:0] pin_s3_q;
	logic [W-1:0] pin_q;
	logic [2:0]   strap_s1_q;
	logic [2:0]   strap_s2_q;
	logic [2:0]   strap_s3_q;
	logic [2:0]   strap_q;
	port_mux_pkg::op_mode_e mode_q;
	port_mux_pkg::op_mode_e mode_d;
	logic [7:0]   rdata_q;
	logic [7:0]   rdata_d;
	logic [W-1:0] drivable;
	logic [W-1:0] sel_d;
	logic         bus_mode;
	logic [2:0]   grp;
	logic [4:0]   port;
	logic         port_ok;

	assign grp      = reg_addr[7:5];
	assign port     = reg_addr[4:0];
	assign port_ok  = port < 5'(port_mux_pkg::PORT_COUNT);
	assign drivable = port_mux_pkg::PIN_EXISTS & ~port_mux_pkg::PIN_INPUT_ONLY; // R02 R03 R04

	// pins: three stages, a change is taken once stages two and three agree
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			// all stages idle high, so release does not fake a falling edge on the break pin
			pin_s1_q <= '1;
			pin_s2_q <= '1;
			pin_s3_q <= '1;
			pin_q    <= '1;
		end else begin
			pin_s1_q <= pin_in;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			pin_q    <= (pin_s2_q & pin_s3_q) | (pin_q & (pin_s2_q ^ pin_s3_q));
		end
	end

	// straps are filtered the same way; mode follows them after reset release
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			strap_s1_q <= '0;
			strap_s2_q <= '0;
			strap_s3_q <= '0;
			strap_q    <= '0;
		end else begin
			strap_s1_q <= {flash_protect_pin, mode_strap_b, mode_strap_a};
			strap_s2_q <= strap_s1_q;
			strap_s3_q <= strap_s2_q;
			strap_q    <= (strap_s2_q & strap_s3_q) | (strap_q & (strap_s2_q ^ strap_s3_q));
		end
	end

	always_comb begin
		case (strap_q)
			3'b000, 3'b100: mode_d = port_mux_pkg::MODE_SINGLE;    // R10
			3'b010, 3'b110: mode_d = port_mux_pkg::MODE_EXTENDED;  // R10
			3'b001:         mode_d = port_mux_pkg::MODE_PROCESSOR; // R10
			3'b101:         mode_d = port_mux_pkg::MODE_BOOT;
			default:        mode_d = port_mux_pkg::MODE_RESERVED;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			mode_q <= port_mux_pkg::MODE_SINGLE;
		end else begin
			mode_q <= mode_d; // R06
		end
	end

	assign bus_mode = (mode_q == port_mux_pkg::MODE_EXTENDED) ||
		(mode_q == port_mux_pkg::MODE_PROCESSOR);

	// function select per pin
	always_comb begin
		sel_d = opmode_q; // R07
		if (mode_q == port_mux_pkg::MODE_EXTENDED) begin
			sel_d[port_mux_pkg::IDX_BUS_FIXED] = 1'b1; // R08
		end else begin
			// boot and reserved fall back to plain ports, the safe choice
			for (int i = 0; i < W; i++) begin
				if (port_mux_pkg::PIN_STRAP_GROUP[i] && i < 40) begin
					sel_d[i] = bus_mode; // R09
				end
			end
		end
		sel_d[port_mux_pkg::IDX_STRAP_P22] = bus_mode; // R06
		sel_d = sel_d & port_mux_pkg::PIN_EXISTS;
	end

	// pin drive: alt function or port latch, input-only bits never enabled
	assign alt_select = sel_d; // R05
	assign pin_out    = ((sel_d & alt_out) | (~sel_d & data_q)) & drivable; // R05
	assign pin_oe     = ((sel_d & alt_oe) | (~sel_d & dir_q)) & drivable;   // R02 R03 R04 R11

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			alt_in               <= '0;
			system_break_request <= 1'b0;
		end else begin
			alt_in               <= pin_q & port_mux_pkg::PIN_EXISTS;
			system_break_request <= ~pin_q[port_mux_pkg::IDX_BREAK]; // R02
		end
	end

	// register writes; masks keep absent bits at zero, and input-only bits too in direction and data
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			dir_q <= {port_mux_pkg::PORT_COUNT{port_mux_pkg::DIR_RESET}}; // R11
		end else if (reg_write && grp == port_mux_pkg::GRP_DIR && port_ok) begin
			dir_q[port*8 +: 8] <= reg_wdata & drivable[port*8 +: 8]; // R01 R03
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			data_q <= {port_mux_pkg::PORT_COUNT{port_mux_pkg::DATA_RESET}};
		end else if (reg_write && grp == port_mux_pkg::GRP_DATA && port_ok) begin
			data_q[port*8 +: 8] <= reg_wdata & drivable[port*8 +: 8];
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			opmode_q <= {port_mux_pkg::PORT_COUNT{port_mux_pkg::OPMODE_RESET}};
		end else if (reg_write && grp == port_mux_pkg::GRP_OPMODE && port_ok) begin
			opmode_q[port*8 +: 8] <= reg_wdata & port_mux_pkg::PIN_EXISTS[port*8 +: 8]; // R07
		end
	end

	// reads: data group shows the filtered pin level, unmapped reads zero
	always_comb begin
		rdata_d = 8'h00;
		if (reg_read) begin
			case (grp)
				port_mux_pkg::GRP_DATA:
					if (port_ok) rdata_d = pin_q[port*8 +: 8] & port_mux_pkg::PIN_EXISTS[port*8 +: 8];
				port_mux_pkg::GRP_DIR:
					if (port_ok) rdata_d = dir_q[port*8 +: 8];
				port_mux_pkg::GRP_OPMODE:
					if (port_ok) rdata_d = opmode_q[port*8 +: 8];
				port_mux_pkg::GRP_STATUS:
					if (port == port_mux_pkg::STATUS_MODE) rdata_d = {5'h00, mode_q};
				default:
					rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_q <= 8'h00;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata    = rdata_q;
	assign op_mode      = mode_q;
	assign mode_invalid = (mode_q == port_mux_pkg::MODE_RESERVED); // R10

endmodule // port_direction_pin_mux

`default_nettype wire

// File: hdl/port_mux_pkg.sv
// Purpose: constants for the port direction and pin function block
// Assumes: port p bit b sits at flat index p*8+b
// Notes:   absent bits are zero in every mask but PIN_STRAP_GROUP, which sets absent port 4 bit 0
package port_mux_pkg;

	localparam int PORT_COUNT = 23;
	localparam int PORT_WIDTH = 8;
	localparam int PIN_COUNT  = PORT_COUNT * PORT_WIDTH;

	// ports that physically exist, port 22 in the top byte
	localparam logic [183:0] PIN_EXISTS =
		184'h23_00_00_00_00_3c_00_09_00_ff_f0_ff_ff_f8_fc_ff_1e_00_fe_ff_ff_ff_ff;
	// bits that may never drive their pin
	localparam logic [183:0] PIN_INPUT_ONLY =
		184'h02_00_00_00_00_0c_00_00_00_ff_f0_00_00_88_00_00_10_00_00_00_00_00_00;
	// ports 0 to 4 and port 22 bit 5 follow the straps
	localparam logic [183:0] PIN_STRAP_GROUP =
		184'h20_00_00_00_00_00_00_00_00_00_00_00_00_00_00_00_00_00_ff_ff_ff_ff_ff;

	localparam int IDX_BREAK      = 6 * 8 + 4;
	localparam int IDX_BUS_FIXED  = 4 * 8 + 6;
	localparam int IDX_STRAP_P22  = 22 * 8 + 5;

	// register map: addr[7:5] selects the group, addr[4:0] the port
	localparam logic [2:0] GRP_DATA   = 3'h0;
	localparam logic [2:0] GRP_DIR    = 3'h1;
	localparam logic [2:0] GRP_OPMODE = 3'h2;
	localparam logic [2:0] GRP_STATUS = 3'h3;
	localparam logic [4:0] STATUS_MODE = 5'h00;

	localparam logic [7:0] DIR_RESET    = 8'h00;
	localparam logic [7:0] DATA_RESET   = 8'h00;
	localparam logic [7:0] OPMODE_RESET = 8'h00;

	typedef enum logic [2:0] {
		MODE_SINGLE    = 3'b000,
		MODE_EXTENDED  = 3'b001,
		MODE_PROCESSOR = 3'b010,
		MODE_BOOT      = 3'b011,
		MODE_RESERVED  = 3'b100
	} op_mode_e;

endpackage

// File: testbench/pin_side_model.sv
// Purpose: outside circuits on the pins
// Assumes: ext_oe is set only where the block stays off
// Notes:   a floating pin toggles each cycle so stale data never match
`timescale 1ns/1ps
`default_nettype none
module pin_side_model (
	input  wire logic         clk,
	input  wire logic [183:0] pin_out,
	input  wire logic [183:0] pin_oe,
	input  wire logic [183:0] ext_val,
	input  wire logic [183:0] ext_oe,
	output logic      [183:0] pin_in
);
	logic [183:0] flt_q = '0;
	always @(posedge clk) flt_q <= ~flt_q;
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_oe & ext_val) | (~ext_oe & flt_q)));
endmodule // pin_side_model
`default_nettype wire

// File: testbench/port_mux_props.sv
// Purpose: pin checks for the port block
// Assumes: straps and pins settle within 7 edges
// Notes:   bound from tb_top
`timescale 1ns/1ps
`default_nettype none
module port_mux_props (
	input wire logic         clk,
	input wire logic         sys_rst,
	input wire logic [7:0]   reg_addr,
	input wire logic [7:0]   reg_wdata,
	input wire logic         reg_write,
	input wire logic         mode_strap_a,
	input wire logic         mode_strap_b,
	input wire logic [183:0] pin_in,
	input wire logic [183:0] pin_oe,
	input wire logic [183:0] alt_select,
	input wire logic         system_break_request,
	input wire logic [2:0]   op_mode,
	input wire logic         mode_invalid
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	sequence ext_s; !mode_strap_a && mode_strap_b; endsequence
	sequence wr7_s; reg_write && reg_addr == 8'h27; endsequence
	dir_pin_a: assert property (wr7_s |=>
		alt_select[63:56] != 0 || pin_oe[63:56] == $past(reg_wdata)) else $error("dir");
	brk_in_a: assert property (!pin_oe[52]) else $error("brk oe");
	brk_req_a: assert property (pin_in[52] [*6] |-> !system_break_request) else $error("brk");
	in_only_a: assert property ((pin_oe & port_mux_pkg::PIN_INPUT_ONLY) == 0)
		else $error("in only");
	ext_mode_a: assert property (ext_s [*7] |-> op_mode == 3'h1 && alt_select[38])
		else $error("ext");
	single_a: assert property (op_mode == 3'h0 |-> alt_select[39:0] == 0) else $error("single");
	proc_a: assert property (op_mode == 3'h2 |-> alt_select[31:0] == '1 && alt_select[181])
		else $error("proc");
	resv_a: assert property (op_mode == 3'h4 |-> mode_invalid) else $error("resv");
	rst_in_a: assert property (disable iff (1'b0) sys_rst |=> pin_oe == 0) else $error("rst");
endmodule // port_mux_props
`default_nettype wire

// File: testbench/tb_top.sv
// Purpose: self-checking bench of the port block
// Assumes: reads answer one cycle after the strobe
// Notes:   read results are queued and matched on the falling edge
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic clk = 0, sys_rst = 1, reg_write = 0, reg_read = 0, rd_pend = 0;
	logic mode_strap_a = 0, mode_strap_b = 0, flash_protect_pin = 0;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, d;
	logic [183:0] pin_in, pin_out, pin_oe, alt_out = 0, alt_oe = 0, alt_in, alt_select;
	logic [183:0] ext_val = 0, ext_oe = 0;
	logic system_break_request, mode_invalid;
	logic [2:0] op_mode;
	logic [2:0] st[5] = '{3'b000, 3'b010, 3'b100, 3'b101, 3'b110};
	logic [7:0] exp_q[$];
	int error_cnt = 0, total_checks = 0, seed = 37, cyc = 0;
	always #5 clk = ~clk;
	port_direction_pin_mux u_port_direction_pin_mux (.clk(clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .mode_strap_a(mode_strap_a), .mode_strap_b(mode_strap_b),
		.flash_protect_pin(flash_protect_pin), .pin_in(pin_in), .pin_out(pin_out),
		.pin_oe(pin_oe), .alt_out(alt_out), .alt_oe(alt_oe), .alt_in(alt_in),
		.alt_select(alt_select), .system_break_request(system_break_request),
		.op_mode(op_mode), .mode_invalid(mode_invalid));
	pin_side_model u_pin_side_model (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
		.ext_val(ext_val), .ext_oe(ext_oe), .pin_in(pin_in));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		reg_write <= 1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_write <= 0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		@(posedge clk);
		reg_read <= 1;
		reg_addr <= a;
		@(posedge clk);
		reg_read <= 0;
		repeat (2) @(posedge clk);
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// read answers come back in request order, so a queue pairs them
	always @(negedge clk) begin
		if (rd_pend) chk("rdata", exp_q.pop_front(), reg_rdata);
		rd_pend = reg_read;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			end_sim();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		chk("oe", 8'h00, {7'h0, |pin_oe});
		sys_rst <= 0;
		for (int p = 0; p < 23; p++) begin
			d = 8'($random(seed));
			wr(8'h20 + p, d);
			rd(8'h20 + p, d & port_mux_pkg::PIN_EXISTS[p*8+:8] & ~port_mux_pkg::PIN_INPUT_ONLY[p*8+:8]);
		end
		d = 8'($random(seed));
		wr(8'h27, 8'hff);
		wr(8'h07, d);
		// the pin filter needs several edges before the new level reads back
		repeat (6) @(posedge clk);
		chk("pout", d, pin_out[63:56]);
		rd(8'h07, d);
		ext_oe[111:104] <= '1;
		ext_val[111:104] <= 8'($random(seed));
		wr(8'h2d, 8'hff);
		repeat (6) @(posedge clk);
		chk("oe13", 8'h00, pin_oe[111:104]);
		rd(8'h0d, ext_val[111:104]);
		alt_oe[63:56] <= '1;
		alt_out[63:56] <= 8'($random(seed));
		wr(8'h47, 8'hff);
		repeat (6) @(posedge clk);
		rd(8'h07, alt_out[63:56]);
		wr(8'h40, 8'h0f);
		for (int k = 0; k < 5; k++) begin
			{mode_strap_a, mode_strap_b, flash_protect_pin} <= st[k];
			repeat (8) @(posedge clk);
			chk("mode", 8'(k), {5'h0, op_mode});
			chk("p0", k == 1 ? 8'h0f : k == 2 ? 8'hff : 8'h00, alt_select[7:0]);
			chk("p22", 8'(k == 1 || k == 2), {7'h0, alt_select[181]});
			chk("inv", 8'(k == 4), {7'h0, mode_invalid});
		end
		ext_oe[52] <= 1'b1;
		for (int k = 0; k < 2; k++) begin
			ext_val[52] <= k[0];
			repeat (8) @(posedge clk);
			chk("brk", 8'(!k[0]), {7'h0, system_break_request});
		end
		sys_rst <= 1;
		repeat (2) @(posedge clk);
		chk("oe", 8'h00, {7'h0, |pin_oe});
		end_sim();
	end
endmodule // tb_top
bind port_direction_pin_mux port_mux_props u_port_mux_props (.clk(clk), .sys_rst(sys_rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
	.mode_strap_a(mode_strap_a), .mode_strap_b(mode_strap_b), .pin_in(pin_in),
	.pin_oe(pin_oe), .alt_select(alt_select), .system_break_request(system_break_request),
	.op_mode(op_mode), .mode_invalid(mode_invalid));
`default_nettype wire
